// ---- rtl/lcdk_pkg.sv ----
// lcdk_pkg: shared constants and carrier types of the lcd key command block
package lcdk_pkg;

	// ****************************************
	// command opcodes (bits 7:6 of a command byte)
	// ****************************************
	localparam logic [1:0] OP_DISP = 2'h0;
	localparam logic [1:0] OP_DATA = 2'h1;
	localparam logic [1:0] OP_ADDR = 2'h2;
	localparam logic [1:0] OP_STAT = 2'h3;
	localparam int         OP_MSB  = 7;
	localparam int         OP_LSB  = 6;

	// ****************************************
	// ram targets and their highest valid address
	// ****************************************
	localparam logic [1:0] TGT_DISP  = 2'h0;
	localparam logic [1:0] TGT_CHAR  = 2'h1;
	localparam logic [1:0] TGT_GLYPH = 2'h2;
	localparam logic [1:0] TGT_LED   = 2'h3;
	localparam logic [4:0] LIM_DISP  = 5'h18;
	localparam logic [4:0] LIM_CHAR  = 5'h07;
	localparam logic [4:0] LIM_GLYPH = 5'h0F;
	localparam logic [4:0] LIM_LED   = 5'h00;
	localparam logic [4:0] ADDR_RST  = 5'h00;

	// ****************************************
	// status lcd field codes
	// ****************************************
	localparam logic [1:0] LCDB_LOW    = 2'h0;
	localparam logic [1:0] LCDB_PROHIB = 2'h1;
	localparam logic [1:0] LCDB_UNSEL  = 2'h2;
	localparam logic [1:0] LCDB_NORMAL = 2'h3;

	// ****************************************
	// key scan geometry and timing
	// ****************************************
	localparam int         NUM_SRC       = 8;
	localparam int         NUM_SENSE     = 4;
	localparam int         KEY_BITS      = NUM_SRC * NUM_SENSE;
	localparam int         CLK_PERIOD_NS = 8;
	localparam int         SCAN_STEP_NS  = 1000;
	localparam int         SCAN_STEP_CYC = (SCAN_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [6:0] STEP_LAST     = 7'(SCAN_STEP_CYC - 1);
	localparam logic [4:0] TX_TOP        = 5'h1F;

	typedef enum logic [1:0] {LCD_LOWBIAS, LCD_UNSEL, LCD_NORMAL} lcdk_lcd_e;

	typedef struct packed {
		logic supply;
		logic master;
		logic coms;
		logic segs;
		logic duty;
	} lcdk_disp_s;

	typedef struct packed {
		logic       fixed_addr;
		logic       read;
		logic [1:0] target;
	} lcdk_dset_s;

	typedef struct packed {
		logic       standby;
		logic [1:0] lcd;
		logic       led;
		logic       scan;
	} lcdk_stat_s;

	typedef struct packed {
		logic [1:0] target;
		logic [4:0] addr;
		logic [7:0] data;
	} lcdk_wr_s;

	localparam lcdk_disp_s DISP_RST = 5'h00;
	localparam lcdk_dset_s DSET_RST = 4'h0;

endpackage : lcdk_pkg

// ---- rtl/lcdk_sync.sv ----
// lcdk_sync: two flip-flop synchroniser for a bundle of levels
module lcdk_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule : lcdk_sync

// ---- rtl/lcdk_link.sv ----
// lcdk_link: serial shifter and open-drain read driver on the link clock
module lcdk_link
	import lcdk_pkg::*;
(
	// clock and reset
	input  wire logic        link_clk,
	input  wire logic        rst,
	// serial pins
	input  wire logic        frame_strobe,
	input  wire logic        serial_data_in,
	output logic             data_out,
	output logic             data_oe,
	// from the command domain
	input  wire logic        rd_active,
	input  wire logic [31:0] rd_word,
	// to the command domain
	output logic [7:0]       rx_byte,
	output logic             rx_is_cmd,
	output logic             rx_tog
);

	// ****************************************
	// frame state, cleared by the strobe itself
	// ****************************************
	// link clock stops between frames, so the strobe must end the frame
	logic       frame_clr;
	logic [2:0] bit_cnt, next_bit_cnt;
	logic [6:0] shreg, next_shreg;
	logic       first, next_first;
	logic       rd_cmd, next_rd_cmd;
	logic [4:0] tx_cnt, next_tx_cnt;
	logic       next_data_oe;
	logic       rd_s, tx, byte_done;
	logic [7:0] next_rx_byte;
	logic       next_rx_is_cmd, next_rx_tog;

	assign frame_clr = rst | ~frame_strobe;

	// refilled every frame: a stale read level would shift the readback
	lcdk_sync #(.W(1)) u_rd_sync (
		.clk (link_clk),
		.rst (frame_clr),
		.d   (rd_active & rd_cmd),
		.q   (rd_s)
	);

	always_comb begin
		tx             = rd_s & ~first;
		byte_done      = (bit_cnt == 3'h7);
		next_bit_cnt   = bit_cnt + 3'h1;
		next_shreg     = {shreg[5:0], serial_data_in};
		next_first     = byte_done ? 1'b0 : first;
		// only a read command of this frame may hand the line to the readback
		next_rd_cmd    = (byte_done && first) ? (shreg[6:5] == OP_DATA && shreg[1]) : rd_cmd;
		next_tx_cnt    = tx ? tx_cnt + 5'h01 : tx_cnt;
		// rd_word is held still while rd_active stands
		next_data_oe   = tx & ~rd_word[TX_TOP - tx_cnt];
		next_rx_byte   = rx_byte;
		next_rx_is_cmd = rx_is_cmd;
		next_rx_tog    = rx_tog;
		if (byte_done && !tx) begin
			next_rx_byte   = {shreg, serial_data_in};
			next_rx_is_cmd = first;
			next_rx_tog    = ~rx_tog;
		end
	end

	always_ff @(posedge link_clk or posedge frame_clr) begin
		if (frame_clr) begin
			bit_cnt <= 3'h0;
			shreg   <= 7'h00;
			first   <= 1'b1;
			rd_cmd  <= 1'b0;
			tx_cnt  <= 5'h00;
			data_oe <= 1'b0;
		end else begin
			bit_cnt <= next_bit_cnt;
			shreg   <= next_shreg;
			first   <= next_first;
			rd_cmd  <= next_rd_cmd;
			tx_cnt  <= next_tx_cnt;
			data_oe <= next_data_oe;
		end
	end

	// ****************************************
	// completed bytes survive the end of a frame
	// ****************************************
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			rx_byte   <= 8'h00;
			rx_is_cmd <= 1'b0;
			rx_tog    <= 1'b0;
			data_out  <= 1'b0;
		end else begin
			rx_byte   <= next_rx_byte;
			rx_is_cmd <= next_rx_is_cmd;
			rx_tog    <= next_rx_tog;
			data_out  <= 1'b0;
		end
	end

	a_first_is_cmd: assert property (@(posedge link_clk) disable iff (frame_clr)
		(byte_done && first && !tx) |=> (rx_is_cmd && rx_byte == $past(next_rx_byte)))
		else $error("first byte of frame not marked as command");

endmodule : lcdk_link

// ---- rtl/lcdk_top.sv ----
// lcdk_top: command decoder, key scan and standby control of the lcd driver
module lcdk_top
	import lcdk_pkg::*;
(
	// clocks and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	input  wire logic                 link_clk,
	// serial link
	input  wire logic                 frame_strobe,
	input  wire logic                 serial_data_in,
	output logic                      data_out,
	output logic                      data_oe,
	// key matrix
	input  wire logic [NUM_SENSE-1:0] key_sense_inputs,
	output logic      [NUM_SRC-1:0]   key_source_lines,
	output logic                      key_source_drive,
	output logic                      key_scan_on,
	output logic                      key_request,
	// display control
	output lcdk_lcd_e                 lcd_mode,
	output logic                      led_enable,
	output logic                      internal_oscillator,
	output logic                      chip_enabled,
	output lcdk_disp_s                disp_cfg,
	// ram write strobe
	output logic                      wr_valid,
	output lcdk_wr_s                  wr
);

	// ****************************************
	// crossing from the link and the key matrix
	// ****************************************
	logic [7:0]           rx_byte;
	logic                 rx_is_cmd, rx_tog, tog_s, tog_d, next_tog_d, byte_evt;
	logic [NUM_SENSE-1:0] key_s;
	logic                 key_any;
	logic                 rd_active, next_rd_active;
	logic [31:0]          rd_word, next_rd_word;

	lcdk_link u_link (
		.link_clk       (link_clk),
		.rst            (rst),
		.frame_strobe   (frame_strobe),
		.serial_data_in (serial_data_in),
		.data_out       (data_out),
		.data_oe        (data_oe),
		.rd_active      (rd_active),
		.rd_word        (rd_word),
		.rx_byte        (rx_byte),
		.rx_is_cmd      (rx_is_cmd),
		.rx_tog         (rx_tog)
	);

	lcdk_sync #(.W(1)) u_tog_sync (
		.clk (ref_clk),
		.rst (rst),
		.d   (rx_tog),
		.q   (tog_s)
	);

	lcdk_sync #(.W(NUM_SENSE)) u_key_sync (
		.clk (ref_clk),
		.rst (rst),
		.d   (key_sense_inputs),
		.q   (key_s)
	);

	assign byte_evt = tog_s ^ tog_d;
	assign key_any  = |key_s;

	// ****************************************
	// command decode
	// ****************************************
	lcdk_dset_s      dset, next_dset;
	lcdk_disp_s      next_disp_cfg;
	lcdk_stat_s      stat;
	lcdk_lcd_e       next_lcd_mode;
	logic [4:0]      addr, next_addr, lim;
	logic            addr_ok;
	logic            standby, next_standby, wake, next_wake;
	logic            next_led_enable, scan_req, next_scan_req;
	logic            prohib, next_prohib, next_chip_enabled;
	logic            next_wr_valid;
	lcdk_wr_s        next_wr;
	logic [KEY_BITS-1:0] key_data;

	always_comb begin
		case (dset.target)
			TGT_DISP:  lim = LIM_DISP;
			TGT_CHAR:  lim = LIM_CHAR;
			TGT_GLYPH: lim = LIM_GLYPH;
			default:   lim = LIM_LED;
		endcase
		addr_ok = (addr <= lim);
		stat    = lcdk_stat_s'(rx_byte[4:0]);
	end

	always_comb begin
		next_tog_d        = tog_s;
		next_dset         = dset;
		next_disp_cfg     = disp_cfg;
		next_addr         = addr;
		next_standby      = standby;
		next_wake         = wake;
		next_lcd_mode     = lcd_mode;
		next_led_enable   = led_enable;
		next_scan_req     = scan_req;
		next_prohib       = prohib;
		next_chip_enabled = chip_enabled;
		next_rd_active    = rd_active;
		next_rd_word      = rd_word;
		next_wr_valid     = 1'b0;
		next_wr           = wr;
		if (standby && key_any) begin
			next_standby = 1'b0;
			next_wake    = 1'b1;
		end
		if (byte_evt && rx_is_cmd) begin
			next_rd_active = 1'b0;
			case (rx_byte[OP_MSB:OP_LSB])
				OP_DISP: begin
					if (lcdk_disp_s'(rx_byte[4:0]) != disp_cfg || !chip_enabled) begin
						next_disp_cfg     = lcdk_disp_s'(rx_byte[4:0]);
						next_chip_enabled = 1'b1;
						next_lcd_mode     = LCD_LOWBIAS;
						next_led_enable   = 1'b1;
						next_scan_req     = 1'b0;
						next_prohib       = 1'b0;
						next_standby      = 1'b0;
					end
				end
				OP_DATA: begin
					next_dset = lcdk_dset_s'(rx_byte[3:0]);
					if (rx_byte[2]) begin
						next_rd_active = 1'b1;
						next_rd_word   = key_data;
					end
				end
				OP_ADDR: begin
					next_addr = rx_byte[4:0];
				end
				OP_STAT: begin
					next_wake = 1'b0;
					if (stat.standby) begin
						next_standby    = 1'b1;
						next_lcd_mode   = LCD_LOWBIAS;
						next_led_enable = 1'b0;
						next_scan_req   = 1'b0;
					end else begin
						next_standby    = 1'b0;
						next_led_enable = stat.led;
						next_scan_req   = stat.scan;
						next_prohib     = (stat.lcd == LCDB_PROHIB);
						case (stat.lcd)
							LCDB_NORMAL: next_lcd_mode = LCD_NORMAL;
							LCDB_UNSEL:  next_lcd_mode = LCD_UNSEL;
							default:     next_lcd_mode = LCD_LOWBIAS;
						endcase
					end
				end
				default: begin
					next_rd_active = 1'b0;
				end
			endcase
		end else if (byte_evt && !dset.read && addr_ok) begin
			next_wr_valid = 1'b1;
			next_wr       = '{target: dset.target, addr: addr, data: rx_byte};
			if (!dset.fixed_addr) begin
				next_addr = (addr == lim) ? ADDR_RST : addr + 5'h01;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tog_d        <= 1'b0;
			dset         <= DSET_RST;
			disp_cfg     <= DISP_RST;
			addr         <= ADDR_RST;
			standby      <= 1'b0;
			wake         <= 1'b0;
			lcd_mode     <= LCD_LOWBIAS;
			led_enable   <= 1'b0;
			scan_req     <= 1'b0;
			prohib       <= 1'b0;
			chip_enabled <= 1'b0;
			rd_active    <= 1'b0;
			rd_word      <= '0;
			wr_valid     <= 1'b0;
			wr           <= '0;
		end else begin
			tog_d        <= next_tog_d;
			dset         <= next_dset;
			disp_cfg     <= next_disp_cfg;
			addr         <= next_addr;
			standby      <= next_standby;
			wake         <= next_wake;
			lcd_mode     <= next_lcd_mode;
			led_enable   <= next_led_enable;
			scan_req     <= next_scan_req;
			prohib       <= next_prohib;
			chip_enabled <= next_chip_enabled;
			rd_active    <= next_rd_active;
			rd_word      <= next_rd_word;
			wr_valid     <= next_wr_valid;
			wr           <= next_wr;
		end
	end

	// ****************************************
	// key scan and request
	// ****************************************
	logic                scan_run, next_key_scan_on, next_key_source_drive;
	logic                next_key_request, next_osc;
	logic [2:0]          src_idx, next_src_idx;
	logic [6:0]          step_cnt, next_step_cnt;
	logic [KEY_BITS-1:0] next_key_data;
	logic [NUM_SRC-1:0]  next_key_source_lines;

	assign scan_run = scan_req & ~prohib & ~standby;

	always_comb begin
		next_key_data         = key_data;
		next_src_idx          = src_idx;
		next_step_cnt         = step_cnt;
		next_osc              = ~standby;
		next_key_scan_on      = scan_run;
		next_key_source_drive = ~standby & ~prohib & (scan_req | (lcd_mode == LCD_NORMAL));
		if (scan_run && !key_scan_on) begin
			// fresh frame: stale keys would look like a press
			next_key_data = '0;
			next_src_idx  = 3'h0;
			next_step_cnt = 7'h00;
		end else if (internal_oscillator && key_source_drive) begin
			if (step_cnt == STEP_LAST) begin
				next_step_cnt = 7'h00;
				next_src_idx  = src_idx + 3'h1;
				if (scan_run) begin
					next_key_data[{src_idx, 2'b00} +: NUM_SENSE] = key_s;
				end
			end else begin
				next_step_cnt = step_cnt + 7'h01;
			end
		end
		if (standby) begin
			next_key_source_lines = '0; // all low: any key can wake
		end else if (next_key_source_drive) begin
			next_key_source_lines = ~(NUM_SRC'(1) << src_idx);
		end else begin
			next_key_source_lines = '1;
		end
		if (scan_run) begin
			next_key_request = |key_data;
		end else if (standby || lcd_mode == LCD_LOWBIAS) begin
			next_key_request = key_any;
		end else begin
			next_key_request = 1'b0;
		end
		next_key_request = next_key_request | wake;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			key_data            <= '0;
			src_idx             <= 3'h0;
			step_cnt            <= 7'h00;
			internal_oscillator <= 1'b1;
			key_scan_on         <= 1'b0;
			key_source_drive    <= 1'b0;
			key_source_lines    <= '1;
			key_request         <= 1'b0;
		end else begin
			key_data            <= next_key_data;
			src_idx             <= next_src_idx;
			step_cnt            <= next_step_cnt;
			internal_oscillator <= next_osc;
			key_scan_on         <= next_key_scan_on;
			key_source_drive    <= next_key_source_drive;
			key_source_lines    <= next_key_source_lines;
			key_request         <= next_key_request;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_disp_init_state: assert property (byte_evt && rx_is_cmd && rx_byte[7:6] == OP_DISP
		&& (lcdk_disp_s'(rx_byte[4:0]) != disp_cfg || !chip_enabled)
		|=> lcd_mode == LCD_LOWBIAS && led_enable && !scan_req && chip_enabled ##1 !key_scan_on)
		else $error("display setting left wrong state");
	a_disp_same_mode: assert property (byte_evt && rx_is_cmd && rx_byte[7:6] == OP_DISP
		&& lcdk_disp_s'(rx_byte[4:0]) == disp_cfg && chip_enabled && !standby
		|=> $stable(lcd_mode) && $stable(led_enable) && $stable(scan_req))
		else $error("same display mode changed state");
	a_bad_addr_drop: assert property (byte_evt && !rx_is_cmd && !addr_ok
		|=> !wr_valid && addr == $past(addr))
		else $error("write or increment at bad address");
	a_addr_increment: assert property (byte_evt && !rx_is_cmd && !dset.read && addr_ok
		&& !dset.fixed_addr && addr < lim |=> wr_valid && addr == $past(addr) + 5'h01)
		else $error("address did not advance");
	a_standby_forces: assert property ($rose(standby)
		|-> !led_enable && lcd_mode == LCD_LOWBIAS ##1 !internal_oscillator && !key_scan_on)
		else $error("standby outputs not forced");
	a_key_wake: assert property (standby && key_any
		|=> !standby ##1 key_request && internal_oscillator)
		else $error("key press did not wake");
	a_keyreq_scan: assert property (scan_run && key_scan_on && !wake
		|=> key_request == $past(|key_data))
		else $error("key request not tied to key data");
	a_prohib_noscan: assert property (prohib |-> ##1 !key_scan_on [*2])
		else $error("scan ran in prohibited mode");
	a_release_quiet: assert property (byte_evt && rx_is_cmd && rx_byte == 8'hC0
		|=> !standby && !led_enable && lcd_mode == LCD_LOWBIAS && !scan_req)
		else $error("plain release did not keep outputs off");

endmodule : lcdk_top

// ---- sim/lcdk_host.sv ----
// lcdk_host: host controller model on the strobed serial link
module lcdk_host (
	// link pins
	output logic      link_clk,
	output logic      frame_strobe,
	output logic      serial_data_in,
	// open-drain readback
	input  wire logic data_out,
	input  wire logic data_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	// pull-up holds the line high while released
	wire data_line = data_oe ? data_out : 1'b1;

	initial begin
		link_clk       = 1'b0;
		frame_strobe   = 1'b0;
		serial_data_in = 1'b0;
	end

	// ****************************************
	// link cycles
	// ****************************************
	task automatic put_bits(input logic [7:0] b, input int n);
		for (int i = 7; i > 7 - n; i--) begin
			serial_data_in = b[i];
			#6 link_clk = 1'b1;
			#6 link_clk = 1'b0;
		end
		// no stale bit left on a line nobody owns
		serial_data_in = ~serial_data_in;
		#100;
	endtask : put_bits

	// first byte of each frame is the command
	task automatic frame(input logic [7:0] b[$], input int last_bits = 8);
		frame_strobe = 1'b1;
		#20;
		foreach (b[i]) put_bits(b[i], (i == b.size() - 1) ? last_bits : 8);
		frame_strobe = 1'b0;
		#60;
	endtask : frame

	// two lead edges fill the readback synchroniser
	task automatic read_keys(output logic [31:0] k);
		frame_strobe = 1'b1;
		#20;
		put_bits(8'h44, 8);
		for (int e = 0; e < 34; e++) begin
			#6 link_clk = 1'b1;
			#6 link_clk = 1'b0;
			if (e >= 2) k[33-e] = data_line;
		end
		frame_strobe = 1'b0;
		#60;
	endtask : read_keys
endmodule : lcdk_host

// ---- sim/lcd_key_command_and_standby_tb.sv ----
// lcd_key_command_and_standby_tb: self-checking bench of the command block
module lcd_key_command_and_standby_tb;
	import lcdk_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic        ref_clk;
	logic        rst;
	logic [3:0]  key_sense_inputs;
	wire         link_clk;
	wire         frame_strobe;
	wire         serial_data_in;
	logic        data_out;
	logic        data_oe;
	logic [7:0]  key_source_lines;
	logic        key_source_drive;
	logic        key_scan_on;
	logic        key_request;
	lcdk_lcd_e   lcd_mode;
	logic        led_enable;
	logic        internal_oscillator;
	logic        chip_enabled;
	lcdk_disp_s  disp_cfg;
	logic        wr_valid;
	lcdk_wr_s    wr;
	logic [14:0] wq[$];
	logic [31:0] keys;
	logic [7:0]  key_src_sel;
	logic [3:0]  key_pat;
	int          num_errors = 0;
	int          checks     = 0;

	lcdk_top i_dut (.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk),
		.frame_strobe(frame_strobe), .serial_data_in(serial_data_in),
		.data_out(data_out), .data_oe(data_oe), .key_sense_inputs(key_sense_inputs),
		.key_source_lines(key_source_lines), .key_source_drive(key_source_drive),
		.key_scan_on(key_scan_on), .key_request(key_request), .lcd_mode(lcd_mode),
		.led_enable(led_enable), .internal_oscillator(internal_oscillator),
		.chip_enabled(chip_enabled), .disp_cfg(disp_cfg), .wr_valid(wr_valid), .wr(wr));

	lcdk_host i_host (.link_clk(link_clk), .frame_strobe(frame_strobe),
		.serial_data_in(serial_data_in), .data_out(data_out), .data_oe(data_oe));

	initial ref_clk = 1'b0;
	always #4 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		if (wr_valid === 1'b1) wq.push_back(wr);
	end

	// key matrix: a pressed key reaches its sense line only while its source is low
	always @(posedge ref_clk) begin
		key_sense_inputs <= (|(key_src_sel & ~key_source_lines)) ? key_pat : 4'h0;
	end

	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic settle;
		repeat (8) @(posedge ref_clk);
		#1;
	endtask : settle

	task automatic chk_writes(input logic [14:0] e[$]);
		settle();
		chk("write count", e.size(), wq.size());
		foreach (e[i]) chk("write", e[i], (i < wq.size()) ? wq[i] : 'x);
		wq.delete();
	endtask : chk_writes

	task automatic give_verdict;
		if (num_errors == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : give_verdict

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_setup;
		chk("chip at reset", 1'b0, chip_enabled);
		i_host.frame('{8'h0D});
		settle();
		chk("cfg", 5'h0D, disp_cfg);
		chk("chip", 1'b1, chip_enabled);
		chk("led", 1'b1, led_enable);
		chk("scan", 1'b0, key_scan_on);
	endtask : t_setup

	task automatic t_writes;
		i_host.frame('{8'h97});
		i_host.frame('{8'h40, 8'hAA, 8'hBB, 8'hCC});
		chk_writes('{15'h17AA, 15'h18BB, 15'h00CC});
		i_host.frame('{8'h88});
		i_host.frame('{8'h41, 8'h11, 8'h22});
		settle();
		chk("dropped writes", 32'h0, wq.size());
		wq.delete();
		i_host.frame('{8'h87});
		i_host.frame('{8'h49, 8'h33, 8'h44});
		chk_writes('{15'h2733, 15'h2744});
		i_host.frame('{8'h8F});
		i_host.frame('{8'h42, 8'h55, 8'h66});
		chk_writes('{15'h4F55, 15'h4066});
	endtask : t_writes

	task automatic t_partial;
		i_host.frame('{8'h82});
		i_host.frame('{8'h40, 8'hFF}, 5);
		i_host.frame('{8'h40, 8'h5A});
		chk_writes('{15'h025A});
	endtask : t_partial

	task automatic t_standby;
		i_host.frame('{8'hDF});
		settle();
		chk("osc off", 1'b0, internal_oscillator);
		chk("led off", 1'b0, led_enable);
		chk("low bias", LCD_LOWBIAS, lcd_mode);
		chk("sources", 8'h00, key_source_lines);
		chk("scan off", 1'b0, key_scan_on);
		@(posedge ref_clk);
		key_src_sel <= 8'h01;
		key_pat     <= 4'h1;
		repeat (10) @(posedge ref_clk);
		#1;
		chk("wake request", 1'b1, key_request);
		chk("wake osc", 1'b1, internal_oscillator);
		@(posedge ref_clk);
		key_src_sel <= 8'h00;
		#10us;
		i_host.frame('{8'hC0});
		settle();
		chk("osc on", 1'b1, internal_oscillator);
		chk("led held", 1'b0, led_enable);
		chk("scan held", 1'b0, key_scan_on);
		chk("request low", 1'b0, key_request);
	endtask : t_standby

	task automatic t_keys;
		i_host.frame('{8'hC9});
		settle();
		chk("scan on", 1'b1, key_scan_on);
		chk("unselected", LCD_UNSEL, lcd_mode);
		@(posedge ref_clk);
		key_src_sel <= 8'h81;
		key_pat     <= 4'h4;
		#10us;
		chk("scan request", 1'b1, key_request);
		i_host.read_keys(keys);
		chk("key data", 32'h40000004, keys);
		@(posedge ref_clk);
		key_src_sel <= 8'h00;
		#10us;
		chk("request cleared", 1'b0, key_request);
	endtask : t_keys

	task automatic t_modes;
		i_host.frame('{8'hC5});
		settle();
		chk("prohibited scan", 1'b0, key_scan_on);
		i_host.frame('{8'hCE});
		settle();
		chk("normal lcd", LCD_NORMAL, lcd_mode);
		chk("normal led", 1'b1, led_enable);
		chk("sources driven", 1'b1, key_source_drive);
		i_host.frame('{8'h0D});
		settle();
		chk("same mode lcd", LCD_NORMAL, lcd_mode);
	endtask : t_modes

	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial begin
		rst              = 1'b1;
		key_src_sel      = 8'h00;
		key_pat          = 4'h0;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		t_setup();
		t_writes();
		t_partial();
		t_standby();
		t_keys();
		t_modes();
		give_verdict();
	end

	// full run is about 40 us of traffic and waits
	initial begin
		#300us;
		num_errors++;
		give_verdict();
	end
endmodule : lcd_key_command_and_standby_tb
